// [hw/itv_dst_cfg.svh]
// Constants for the interval trigger and down-count start block
// Behaviour
// RULE1: Trigger select clears on reset and standby
// RULE2: A/D pulse is counter bit rise AND enable
// RULE3: Interval enable AND rise sets flag, interrupts
// RULE4: Zero enable bit suppresses pulse and flag
// RULE5: Eight run bits, one per down-counter
// RULE6: Software writes only set run bits
// RULE7: Run bit clears on its counter underflow
// RULE8: Linked compare-match sets run bit in offset mode
// RULE9: Offset mode also clears on underflow, software sets
// RULE10: Run control clears on reset and standby
// RULE11: Bit 7 set by channel 2 register B match
// RULE12: Bit 6 by c2 A, bits 5-0 by c1 F-A
// RULE13: Link enable register 8 bits RW, resets zero
// RULE14: Rising edge is zero-to-one between samples
`ifndef ITV_DST_CFG_SVH
`define ITV_DST_CFG_SVH
`define ADR_TRIG_SEL 4'h0
`define ADR_RUN_CTRL 4'h1
`define ADR_LINK_EN 4'h2
`define ADR_IRQ_STAT 4'h3
`define ADR_IRQ_CLR 4'h4
`define ADR_IRQ_EN 4'h5
`define ADR_FLAGS 4'h6
`define RST_BYTE 8'h00
`define TAP_LSB 10
`define TAP_MSB 13
`define ADC_EN_LSB 4
`define INTV_EN_LSB 0
`define EV_INTV_LSB 0
`define EV_UFLOW_LSB 8
`define EV_WIDTH 16
`endif

// [hw/itv_dst_pkg.sv]
// Types for the interval trigger and down-count start block
package itv_dst_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] nib_t;
endpackage : itv_dst_pkg

// [hw/rise_detect.sv]
// Rising edge detector bank, one-cycle pulse per zero-to-one change
module rise_detect #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] prev_q;
    logic [W-1:0] prev_d;

    always_comb begin
        // Keep tracking during standby; zeroing here would fake a rise on exit
        prev_d = level;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_q <= '0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // Suppressed during standby so no edge fires while standby is high
    assign rise = level & ~prev_q & {W{~clear}}; // RULE14
endmodule : rise_detect

// [hw/itv_dst.sv]
// Interval trigger and down-count start control with Wishbone slave
`include "itv_dst_cfg.svh"
module itv_dst (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic standby,
    input wire logic [15:0] free_run_count,
    input wire logic [7:0] cmp_match,
    input wire logic offset_mode,
    input wire logic [7:0] uflow,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [3:0] adc_trig,
    output itv_dst_pkg::nib_t intv_irq_req,
    output itv_dst_pkg::byte_t run_flags,
    output logic irq
);
    import itv_dst_pkg::*;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction : hit

    byte_t trig_sel_q, trig_sel_d;
    byte_t run_q, run_d;
    byte_t link_q, link_d;
    logic [`EV_WIDTH-1:0] stat_q, stat_d;
    logic [`EV_WIDTH-1:0] en_q, en_d;
    nib_t flag_q, flag_d;
    logic [31:0] rdat_q, rdat_d;
    logic ack_q, ack_d;
    logic err_q, err_d;
    nib_t adc_q, adc_d;
    nib_t iq_q, iq_d;
    nib_t rise;
    logic req, wr, b0, b1, mapped;
    byte_t wbyte;
    logic [`EV_WIDTH-1:0] wword, ev;
    byte_t set_hw;

    rise_detect #(.W(4)) u_rise (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(standby),
        .level(free_run_count[`TAP_MSB:`TAP_LSB]), // RULE14
        .rise(rise)
    );

    assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    assign wr = req & wb_we_i;
    assign b0 = wb_sel_i[0];
    assign b1 = wb_sel_i[1];
    assign wbyte = wb_dat_i[7:0];
    assign wword = {b1 ? wb_dat_i[15:8] : 8'h00, b0 ? wb_dat_i[7:0] : 8'h00};
    assign mapped = hit(wb_adr_i, `ADR_TRIG_SEL) | hit(wb_adr_i, `ADR_RUN_CTRL)
        | hit(wb_adr_i, `ADR_LINK_EN) | hit(wb_adr_i, `ADR_IRQ_STAT)
        | hit(wb_adr_i, `ADR_IRQ_CLR) | hit(wb_adr_i, `ADR_IRQ_EN)
        | hit(wb_adr_i, `ADR_FLAGS);

    // Compare-match sets only where linked; mapping c2B,c2A,c1F..c1A on bits 7..0
    assign set_hw = offset_mode ? (cmp_match & link_q) : `RST_BYTE; // RULE8 RULE11 RULE12

    // Events: interval flags low nibble, underflows of running counters high byte
    assign ev = {uflow & run_q, 4'h0,
        rise & trig_sel_q[`INTV_EN_LSB +: 4]}; // RULE3 RULE4

    always_comb begin
        trig_sel_d = trig_sel_q;
        run_d = run_q;
        link_d = link_q;
        en_d = en_q;
        flag_d = flag_q;
        stat_d = stat_q;
        if (wr && b0 && hit(wb_adr_i, `ADR_TRIG_SEL)) begin
            trig_sel_d = wbyte;
        end
        if (wr && b0 && hit(wb_adr_i, `ADR_LINK_EN)) begin
            link_d = wbyte; // RULE13
        end
        if (wr && hit(wb_adr_i, `ADR_IRQ_EN)) begin
            en_d = wword;
        end
        if (wr && hit(wb_adr_i, `ADR_IRQ_CLR)) begin
            stat_d = stat_q & ~wword;
        end
        stat_d = stat_d | ev;
        // Interval flags: software clears by writing one, new edge wins
        if (wr && b0 && hit(wb_adr_i, `ADR_FLAGS)) begin
            flag_d = flag_q & ~wbyte[3:0];
        end
        flag_d = flag_d | (rise & trig_sel_q[`INTV_EN_LSB +: 4]); // RULE3
        // Underflow clears first; a same-cycle set (software or match) wins
        run_d = run_q & ~uflow; // RULE7 RULE9
        if (wr && b0 && hit(wb_adr_i, `ADR_RUN_CTRL)) begin
            run_d = run_d | wbyte; // RULE6 RULE9
        end
        run_d = run_d | set_hw; // RULE8
        if (standby) begin
            trig_sel_d = `RST_BYTE; // RULE1
            run_d = `RST_BYTE; // RULE10
        end
    end

    always_comb begin
        adc_d = rise & trig_sel_q[`ADC_EN_LSB +: 4]; // RULE2 RULE4
        iq_d = rise & trig_sel_q[`INTV_EN_LSB +: 4]; // RULE3
        ack_d = req & mapped;
        err_d = req & ~mapped;
        rdat_d = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (1'b1)
                hit(wb_adr_i, `ADR_TRIG_SEL): rdat_d[7:0] = trig_sel_q;
                hit(wb_adr_i, `ADR_RUN_CTRL): rdat_d[7:0] = run_q; // RULE5
                hit(wb_adr_i, `ADR_LINK_EN): rdat_d[7:0] = link_q;
                hit(wb_adr_i, `ADR_IRQ_STAT): rdat_d[15:0] = stat_q;
                hit(wb_adr_i, `ADR_IRQ_EN): rdat_d[15:0] = en_q;
                hit(wb_adr_i, `ADR_FLAGS): rdat_d[3:0] = flag_q;
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trig_sel_q <= `RST_BYTE; // RULE1
            run_q <= `RST_BYTE; // RULE10
            link_q <= `RST_BYTE; // RULE13
            stat_q <= '0;
            en_q <= '0;
            flag_q <= 4'h0;
        end else begin
            trig_sel_q <= trig_sel_d;
            run_q <= run_d;
            link_q <= link_d;
            stat_q <= stat_d;
            en_q <= en_d;
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdat_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            adc_q <= 4'h0;
            iq_q <= 4'h0;
        end else begin
            rdat_q <= rdat_d;
            ack_q <= ack_d;
            err_q <= err_d;
            adc_q <= adc_d;
            iq_q <= iq_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign adc_trig = adc_q;
    assign intv_irq_req = iq_q;
    assign run_flags = run_q; // RULE5
    assign irq = |(stat_q & en_q);
endmodule : itv_dst

// [testbench/far_side_model.sv]
// Stand-in for the A/D converter and interrupt controller
module far_side_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] adc_trig,
    input wire itv_dst_pkg::nib_t intv_irq_req,
    output logic [3:0] adc_seen,
    output logic [3:0] req_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sticky record of which taps fired
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            adc_seen <= 4'h0;
            req_seen <= 4'h0;
        end else begin
            adc_seen <= adc_seen | adc_trig;
            req_seen <= req_seen | intv_irq_req;
        end
    end
endmodule : far_side_model

// [testbench/itv_dst_sva.sv]
// Port assertions for the interval trigger and down-count start block
module itv_dst_sva (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic standby,
    input wire logic [15:0] free_run_count,
    input wire logic [7:0] cmp_match,
    input wire logic offset_mode,
    input wire logic [7:0] uflow,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [3:0] adc_trig,
    input wire itv_dst_pkg::nib_t intv_irq_req,
    input wire itv_dst_pkg::byte_t run_flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic [3:0] tap = free_run_count[13:10];
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    a_bus_answer: assert property (s_take |=> (wb_ack_o || wb_err_o) ##1 !wb_ack_o)
        else $error("bus answer late or long");
    a_adc_cause: assert property (adc_trig != 4'h0 |-> (adc_trig & ~($past(tap) & ~$past(tap, 2))) == 4'h0)
        else $error("adc pulse without tap rise");
    a_req_cause: assert property (intv_irq_req != 4'h0 |-> (intv_irq_req & ~($past(tap) & ~$past(tap, 2))) == 4'h0)
        else $error("interval request without tap rise");
    a_req_single: assert property (intv_irq_req != 4'h0 |=> (intv_irq_req & $past(intv_irq_req)) == 4'h0)
        else $error("interval request too long");
    a_standby_clear: assert property (standby |=> run_flags == 8'h00)
        else $error("run bits survive standby");
    a_uflow_clear: assert property ((uflow & ~cmp_match) != 8'h00 && !wb_stb_i |=> (run_flags & $past(uflow)) == 8'h00)
        else $error("run bit kept after underflow");
    a_run_rise: assert property ((run_flags & ~$past(run_flags) & ~$past(cmp_match & {8{offset_mode}})) != 8'h00 |-> $past(wb_stb_i && wb_we_i))
        else $error("run bit set without cause");
    a_run_fall: assert property ((~run_flags & $past(run_flags) & ~$past(uflow)) != 8'h00 |-> $past(standby))
        else $error("run bit cleared without cause");
endmodule : itv_dst_sva
bind itv_dst itv_dst_sva i_itv_dst_sva (.*);

// [testbench/itv_dst_tb.sv]
// Self-checking bench for the interval trigger and down-count start block
module itv_dst_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import itv_dst_pkg::*;
    logic clk_sys = 0, resetn = 0, standby = 0, offset_mode = 0;
    logic [15:0] free_run_count = 16'h0000;
    logic [7:0] cmp_match = 8'h00, uflow = 8'h00;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o, irq, er;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, adc_trig, adc_seen, req_seen;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    nib_t intv_irq_req;
    byte_t run_flags;
    int err_total = 0, compares = 0, cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    itv_dst i_itv_dst (.*);
    far_side_model i_far_side_model (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_adr_i, wb_we_i, wb_dat_i} <= {2'h3, a, we, d};
        do @(posedge clk_sys); while (!(wb_ack_o || wb_err_o));
        rd = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic stop_test;
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic t_regs;
        wb(4'h0, 1'h0, 32'h0);
        chk(rd, 32'h0);
        wb(4'h1, 1'h0, 32'h0);
        chk(rd, 32'h0);
        wb(4'h2, 1'h1, 32'hA5);
        wb(4'h2, 1'h0, 32'h0);
        chk(rd, 32'hA5);
        wb(4'h7, 1'h0, 32'h0);
        chk(er, 1'h1);
    endtask : t_regs
    task automatic t_interval;
        wb(4'h5, 1'h1, 32'h1);
        wb(4'h0, 1'h1, 32'h81);
        free_run_count <= 16'h3C00;
        repeat (4) @(posedge clk_sys);
        chk(adc_seen, 4'h8);
        chk(req_seen, 4'h1);
        chk(irq, 1'h1);
        wb(4'h6, 1'h0, 32'h0);
        chk(rd, 32'h1);
        wb(4'h6, 1'h1, 32'h1);
        wb(4'h6, 1'h0, 32'h0);
        chk(rd, 32'h0);
        wb(4'h5, 1'h1, 32'h0);
        chk(irq, 1'h0);
        wb(4'h4, 1'h1, 32'h1);
        wb(4'h5, 1'h1, 32'h1);
        chk(irq, 1'h0);
    endtask : t_interval
    task automatic t_run;
        wb(4'h1, 1'h1, 32'h05);
        wb(4'h1, 1'h1, 32'h02);
        chk(run_flags, 8'h07);
        uflow <= 8'h01;
        @(posedge clk_sys) uflow <= 8'h00;
        @(posedge clk_sys) chk(run_flags, 8'h06);
        wb(4'h2, 1'h1, 32'h80);
        {offset_mode, cmp_match} <= {1'h1, 8'hC0};
        @(posedge clk_sys) cmp_match <= 8'h00;
        @(posedge clk_sys) chk(run_flags, 8'h86);
        standby <= 1'h1;
        @(posedge clk_sys) standby <= 1'h0;
        @(posedge clk_sys) chk(run_flags, 8'h00);
        wb(4'h0, 1'h0, 32'h0);
        chk(rd, 32'h0);
    endtask : t_run
    // Ceiling well above the fewer than one hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 2000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'h1;
        t_regs();
        t_interval();
        t_run();
        stop_test();
    end
endmodule : itv_dst_tb
